// ==== hw/mmc_pkg.sv ====
/*
 * constants for the module management control and status sequencer.
 * assumes a 250 MHz system clock; init, reset, low power pin, irq-off, select and power-down-off times are converted to cycle counts here.
 */
package mmc_pkg;

	// ****************************************
	// clock
	// ****************************************
	localparam int unsigned CLK_MHZ = 250;

	// ****************************************
	// times, in their natural units
	// ****************************************
	localparam int unsigned T_INIT_MS = 2000;
	localparam int unsigned T_RESET_MIN_US = 2;
	localparam int unsigned T_LOWPWR_PIN_US = 100;
	localparam int unsigned T_IRQ_ON_MS = 200;
	localparam int unsigned T_IRQ_OFF_US = 500;
	localparam int unsigned T_LOS_MS = 100;
	localparam int unsigned T_MASK_MS = 100;
	localparam int unsigned T_SEL_US = 100;
	localparam int unsigned T_PDOWN_ON_MS = 100;
	localparam int unsigned T_PDOWN_OFF_MS = 300;

	// ****************************************
	// cycle counts (longest times computed in 64 bits)
	// ****************************************
	localparam longint unsigned INIT_CYC = longint'(T_INIT_MS) * 1000 * CLK_MHZ;
	localparam int unsigned RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
	localparam int unsigned LOWPWR_PIN_CYC = T_LOWPWR_PIN_US * CLK_MHZ;
	localparam int unsigned IRQ_OFF_CYC = T_IRQ_OFF_US * CLK_MHZ;
	localparam int unsigned SEL_CYC = T_SEL_US * CLK_MHZ;
	localparam longint unsigned PDOWN_OFF_CYC = longint'(T_PDOWN_OFF_MS) * 1000 * CLK_MHZ;

	// internal latency actually used, far inside every bound above
	localparam int unsigned SEL_DLY_CYC = 4;

	// ****************************************
	// flags
	// ****************************************
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned NUM_OTHER = 4;
	localparam int unsigned NUM_FLAGS = 2 * NUM_CH + NUM_OTHER;
	localparam int unsigned FLAG_LOS_LSB = 0;
	localparam int unsigned FLAG_TXF_LSB = 4;
	localparam int unsigned FLAG_OTH_LSB = 8;

	// status byte 2: data-not-ready is bit 0
	localparam int unsigned STAT_DNR_BIT = 0;

	// ****************************************
	// power states
	// ****************************************
	typedef enum logic [1:0] {
		MMC_ST_INIT = 2'b00,
		MMC_ST_RUN = 2'b01,
		MMC_ST_LOWPWR = 2'b10,
		MMC_ST_WAKE = 2'b11
	} mmc_state_t;

endpackage

// ==== hw/mmc_sync2.sv ====
/*
 * two flip-flop synchroniser, one bit per lane.
 * assumes inputs are asynchronous to sys_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module mmc_sync2 #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // mmc_sync2
`default_nettype wire

// ==== hw/mmc_ctrl.sv ====
/*
 * control and status sequencing of a pluggable module's management side:
 * init window, module reset pin, select gating, latched flags, masks,
 * clear-on-read, interrupt pin, low power pin and power-down bit.
 * assumes the two-wire slave engine sits beside it on sys_clk_i and reports
 * reads, writes and stop conditions as one-cycle pulses.
 */
// Operation
// RQ1: fully functional within init time after power
// RQ2: reset pin low beyond minimum is reset
// RQ3: serial bus answers within init time
// RQ4: clear data-not-ready and assert interrupt
// RQ5: functional within init time after reset release
// RQ6: low power pin high enters low power
// RQ7: interrupt pin low after triggering condition
// RQ8: flag read clears, interrupt releases shortly
// RQ9: loss of signal sets flag and interrupt
// RQ10: transmit fault sets flag and interrupt
// RQ11: other conditions set flag and interrupt
// RQ12: mask set inhibits its flag's interrupt
// RQ13: mask cleared resumes its flag's interrupt
// RQ14: select low enables serial responses
// RQ15: select high stops serial responses
// RQ16: power-down bit set enters low power
// RQ17: power-down bit cleared returns to functional
// RQ18: functional means interrupt from data-ready
// RQ19: write times counted from stop edge
// RQ20: host reads flags after interrupt
// RQ21: host waits for readiness before transactions
`timescale 1ns/10ps
`default_nettype none
module mmc_ctrl #(
	parameter longint unsigned INIT_CYC = mmc_pkg::INIT_CYC,
	parameter longint unsigned PDOWN_OFF_CYC = mmc_pkg::PDOWN_OFF_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// module pins from the host
	input wire logic module_rst_low_in_i,
	input wire logic module_select_n_i,
	input wire logic low_power_pin_i,
	// raw conditions from the optics
	input wire logic [mmc_pkg::NUM_CH-1:0] rx_los_i,
	input wire logic [mmc_pkg::NUM_CH-1:0] tx_fault_i,
	input wire logic [mmc_pkg::NUM_OTHER-1:0] other_cond_i,
	// serial slave engine events
	input wire logic flag_read_stop_i,
	input wire logic [mmc_pkg::NUM_FLAGS-1:0] flag_read_sel_i,
	input wire logic ctrl_write_stop_i,
	input wire logic [mmc_pkg::NUM_FLAGS-1:0] mask_wdata_i,
	input wire logic pdown_wdata_i,
	// status towards the serial slave engine
	output logic bus_respond_o,
	output logic [mmc_pkg::NUM_FLAGS-1:0] flags_o,
	output logic [mmc_pkg::NUM_FLAGS-1:0] mask_o,
	output logic pdown_o,
	output logic data_not_ready_o,
	// module pins to the host and power
	output logic irq_out_n_o,
	output logic low_power_o,
	output logic functional_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic rst_pin_s;
	logic sel_n_s;
	logic lp_pin_s;
	logic [mmc_pkg::NUM_FLAGS-1:0] cond_s;
	logic [mmc_pkg::NUM_FLAGS-1:0] cond_raw;

	assign cond_raw = {other_cond_i, tx_fault_i, rx_los_i};

	mmc_sync2 #(.W(3 + mmc_pkg::NUM_FLAGS), .RST_VAL({3'h6, {mmc_pkg::NUM_FLAGS{1'b0}}})) u_sync (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.d_i({module_rst_low_in_i, module_select_n_i, low_power_pin_i, cond_raw}),
		.q_o({rst_pin_s, sel_n_s, lp_pin_s, cond_s})
	);

	// ****************************************
	// reset pin qualification
	// ****************************************
	logic [9:0] rst_cnt;
	logic pin_reset;
	wire rst_long = (rst_cnt >= 10'(mmc_pkg::RESET_MIN_CYC));
	wire [9:0] next_rst_cnt = rst_pin_s ? 10'h000 : (rst_long ? rst_cnt : rst_cnt + 10'h001);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_cnt <= 10'h000;
			pin_reset <= 1'b0;
		end else begin
			rst_cnt <= next_rst_cnt;
			// a low beyond the minimum pulse holds the module in reset until release
			pin_reset <= rst_pin_s ? 1'b0 : (rst_long | pin_reset); // RQ2
		end
	end

	// ****************************************
	// power sequencer
	// ****************************************
	mmc_pkg::mmc_state_t state;
	mmc_pkg::mmc_state_t next_state;
	logic [31:0] tmr;
	logic [31:0] next_tmr;
	logic dnr;
	logic dnr_clear_ev;
	wire lp_req = lp_pin_s | pdown_o;
	wire init_done = (tmr >= 32'(INIT_CYC - 1));
	wire wake_done = (tmr >= 32'(PDOWN_OFF_CYC - 1));

	always_comb begin
		next_state = state;
		next_tmr = tmr + 32'h1;
		dnr_clear_ev = 1'b0;
		case (state)
			mmc_pkg::MMC_ST_INIT: begin
				// init ends at the longest allowed time, which also opens the bus
				if (init_done) begin // RQ1 RQ3 RQ5
					dnr_clear_ev = 1'b1; // RQ4
					next_state = lp_req ? mmc_pkg::MMC_ST_LOWPWR : mmc_pkg::MMC_ST_RUN;
					next_tmr = 32'h0;
				end
			end
			mmc_pkg::MMC_ST_RUN: begin
				next_tmr = 32'h0;
				if (lp_req) begin // RQ6 RQ16
					next_state = mmc_pkg::MMC_ST_LOWPWR;
				end
			end
			mmc_pkg::MMC_ST_LOWPWR: begin
				next_tmr = 32'h0;
				if (!lp_req) begin
					next_state = mmc_pkg::MMC_ST_WAKE;
				end
			end
			mmc_pkg::MMC_ST_WAKE: begin
				if (lp_req) begin
					next_state = mmc_pkg::MMC_ST_LOWPWR;
					next_tmr = 32'h0;
				end else if (wake_done) begin // RQ17
					next_state = mmc_pkg::MMC_ST_RUN;
					next_tmr = 32'h0;
				end
			end
			default: begin
				next_state = mmc_pkg::MMC_ST_INIT;
				next_tmr = 32'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= mmc_pkg::MMC_ST_INIT;
			tmr <= 32'h0;
			dnr <= 1'b1;
		end else if (pin_reset) begin // RQ2 RQ5
			state <= mmc_pkg::MMC_ST_INIT;
			tmr <= 32'h0;
			dnr <= 1'b1;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			if (dnr_clear_ev) begin
				dnr <= 1'b0; // RQ4
			end
		end
	end

	wire in_init = (state == mmc_pkg::MMC_ST_INIT) | pin_reset;
	assign data_not_ready_o = dnr;
	assign low_power_o = (state == mmc_pkg::MMC_ST_LOWPWR);
	assign functional_o = !dnr & (state == mmc_pkg::MMC_ST_RUN) & !pin_reset; // RQ18

	// ****************************************
	// select gating
	// ****************************************
	logic [2:0] sel_cnt;
	logic selected;
	wire sel_settled = (sel_cnt == 3'(mmc_pkg::SEL_DLY_CYC - 1));

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_cnt <= 3'h0;
			selected <= 1'b0;
		end else if ((!sel_n_s) == selected) begin
			sel_cnt <= 3'h0;
		end else if (sel_settled) begin
			sel_cnt <= 3'h0;
			selected <= !sel_n_s; // RQ14 RQ15
		end else begin
			sel_cnt <= sel_cnt + 3'h1;
		end
	end

	assign bus_respond_o = selected & !in_init; // RQ3 RQ14 RQ15 RQ21

	// ****************************************
	// control registers written by the host
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mask_o <= {mmc_pkg::NUM_FLAGS{1'b0}};
			pdown_o <= 1'b0;
		end else if (pin_reset) begin
			mask_o <= {mmc_pkg::NUM_FLAGS{1'b0}};
			pdown_o <= 1'b0;
		end else if (ctrl_write_stop_i) begin
			// take effect on the stop of the write transaction
			mask_o <= mask_wdata_i; // RQ12 RQ13 RQ19
			pdown_o <= pdown_wdata_i; // RQ16 RQ17 RQ19
		end
	end

	// ****************************************
	// latched flags, clear on read
	// ****************************************
	logic [mmc_pkg::NUM_FLAGS-1:0] cond_d;
	logic ready_irq;
	wire [mmc_pkg::NUM_FLAGS-1:0] rise = cond_s & ~cond_d;
	wire [mmc_pkg::NUM_FLAGS-1:0] rd_clr = flag_read_sel_i & {mmc_pkg::NUM_FLAGS{flag_read_stop_i}};

	genvar g;
	generate
		for (g = 0; g < mmc_pkg::NUM_FLAGS; g++) begin : g_flag
			always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					flags_o[g] <= 1'b0;
				end else if (in_init) begin
					flags_o[g] <= 1'b0;
				end else if (rise[g]) begin
					// a new event beats a clear in the same cycle
					flags_o[g] <= 1'b1; // RQ9 RQ10 RQ11
				end else if (rd_clr[g]) begin
					flags_o[g] <= 1'b0; // RQ8
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cond_d <= {mmc_pkg::NUM_FLAGS{1'b0}};
			ready_irq <= 1'b0;
		end else begin
			cond_d <= cond_s;
			if (dnr_clear_ev & !pin_reset) begin
				ready_irq <= 1'b1; // RQ4 RQ18
			end else if (in_init) begin
				ready_irq <= 1'b0;
			end else if (flag_read_stop_i) begin
				// any flag-field read acknowledges the readiness interrupt
				ready_irq <= 1'b0; // RQ8
			end
		end
	end

	// ****************************************
	// interrupt pin
	// ****************************************
	wire irq_any = ready_irq | (|(flags_o & ~mask_o)); // RQ7 RQ12 RQ13 RQ20

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_out_n_o <= 1'b1;
		end else begin
			irq_out_n_o <= !irq_any; // RQ7 RQ8
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_flag_set_irq: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ9
		(rise[0] & !in_init & !mask_o[0]) |=> (flags_o[0] ##1 !irq_out_n_o))
		else $error("los event did not raise flag and interrupt");
	chk_tx_fault_flag: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ10
		(rise[4] & !in_init) |=> flags_o[4])
		else $error("tx fault event did not set flag");
	chk_read_clears: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ8
		(rd_clr[8] & !rise[8] & !in_init) |=> !flags_o[8])
		else $error("flag read did not clear flag");
	chk_irq_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ8
		(flag_read_stop_i & (&flag_read_sel_i) & !(|rise) & !in_init) |=> ##1 irq_out_n_o)
		else $error("interrupt pin not released");
	chk_mask_inhibit: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ12
		(&mask_o & !ready_irq) |=> irq_out_n_o)
		else $error("masked flags still drive interrupt");
	chk_mask_takes: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ19
		(ctrl_write_stop_i & !pin_reset) |=> (mask_o == $past(mask_wdata_i)))
		else $error("mask not taken on write stop");
	chk_dnr_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ4
		(dnr_clear_ev & !pin_reset) |=> (!dnr & ready_irq) ##1 !irq_out_n_o)
		else $error("data ready did not raise interrupt");
	chk_lowpwr_entry: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ6
		(state == mmc_pkg::MMC_ST_RUN & lp_req & !pin_reset) |=> low_power_o)
		else $error("low power not entered");
	chk_no_bus_init: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ3
		(state == mmc_pkg::MMC_ST_INIT & !init_done) |=> (!bus_respond_o & dnr))
		else $error("bus answered during init");
	chk_sel_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ15
		(sel_n_s & selected) [*4] |=> !selected)
		else $error("select release not honoured");
	chk_pin_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ2
		(pin_reset) |=> (state == mmc_pkg::MMC_ST_INIT & dnr))
		else $error("pin reset not applied");
	chk_bus_ready: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ3
		(dnr_clear_ev & !pin_reset & selected & !sel_n_s) |=> (bus_respond_o | pin_reset))
		else $error("bus not answering after init");
	chk_init_restart: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ5
		$fell(pin_reset) |-> (state == mmc_pkg::MMC_ST_INIT & tmr == 32'h0))
		else $error("init timer not restarted after pin reset");
	chk_dnr_stays: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ4 RQ18
		(!dnr & !pin_reset) |=> !dnr)
		else $error("data not ready raised without reset");
	chk_other_flag: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ11
		(rise[8] & !in_init) |=> flags_o[8])
		else $error("other event did not set flag");
	chk_mask_resume: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ13
		(ctrl_write_stop_i & !in_init & (mask_wdata_i == {mmc_pkg::NUM_FLAGS{1'b0}})
			& (|flags_o) & !(|rd_clr)) |=> ##1 !irq_out_n_o)
		else $error("cleared mask did not resume interrupt");
	chk_pdown_entry: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ16
		(ctrl_write_stop_i & pdown_wdata_i & !pin_reset & (state == mmc_pkg::MMC_ST_RUN))
			|=> ##1 (low_power_o | $past(pin_reset)))
		else $error("power-down bit did not enter low power");
	chk_wake_return: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ17
		((state == mmc_pkg::MMC_ST_WAKE) & wake_done & !lp_req & !pin_reset)
			|=> (functional_o | pin_reset))
		else $error("wake did not return to functional");
	chk_sel_respond: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ14
		(!sel_n_s & !selected) [*4] |=> selected)
		else $error("select assert not honoured");

	cov_ready: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) dnr_clear_ev);
	cov_flag_clear: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		flags_o[0] ##1 rd_clr[0]);
	cov_wake: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		state == mmc_pkg::MMC_ST_WAKE ##1 state == mmc_pkg::MMC_ST_RUN);
	cov_sel: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(bus_respond_o));
	cov_pin_reset: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(pin_reset));

endmodule // mmc_ctrl
`default_nettype wire

// ==== bench/mmc_host_model.sv ====
/*
 * host controller model: drives the module pins and the serial event pulses.
 * assumes sys_clk_i is the module clock; every change is made at the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
	// clock
	input wire logic sys_clk_i,
	// readiness seen from the module
	input wire logic data_not_ready_i,
	// pins to the module
	output logic module_rst_low_in_o,
	output logic module_select_n_o,
	output logic low_power_pin_o,
	// serial events to the module
	output logic flag_read_stop_o,
	output logic [mmc_pkg::NUM_FLAGS-1:0] flag_read_sel_o,
	output logic ctrl_write_stop_o,
	output logic [mmc_pkg::NUM_FLAGS-1:0] mask_wdata_o,
	output logic pdown_wdata_o
);
	// ****************************************
	// pins and transfers
	// ****************************************
	initial begin
		{module_rst_low_in_o, module_select_n_o, low_power_pin_o} = 3'b100;
		{flag_read_stop_o, ctrl_write_stop_o, pdown_wdata_o} = 3'b000;
		flag_read_sel_o = 12'h000;
		mask_wdata_o = 12'h000;
	end

	task automatic pins(input logic rst_low, input logic sel_n, input logic lp);
		module_rst_low_in_o = rst_low;
		module_select_n_o = sel_n;
		low_power_pin_o = lp;
	endtask

	// rd high: read covering flags v; rd low: control write of mask v and power-down pd
	task automatic xfer(input logic rd, input logic [11:0] v, input logic pd);
		int n;
		n = 0;
		while (data_not_ready_i !== 1'b0 && n < 1000) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (rd) begin
			flag_read_sel_o = v;
			flag_read_stop_o = 1'b1;
		end else begin
			mask_wdata_o = v;
			pdown_wdata_o = pd;
			ctrl_write_stop_o = 1'b1;
		end
		@(negedge sys_clk_i);
		// released lines carry the inverted last value, not the last value
		{flag_read_stop_o, ctrl_write_stop_o} = 2'b00;
		flag_read_sel_o = ~v;
		mask_wdata_o = ~v;
		pdown_wdata_o = ~pd;
	endtask
endmodule // mmc_host_model
`default_nettype wire

// ==== bench/tb_module_mgmt_ctrl_status_timing.sv ====
/*
 * self-checking bench for the management control and status sequencer.
 * assumes mmc_pkg and mmc_ctrl are compiled first; inputs change at the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_module_mgmt_ctrl_status_timing;
	localparam int INIT = 100;
	localparam int PDOFF = 50;
	logic sys_clk_i, arst_n_i;
	logic [11:0] cond, flags, mask, rsel, wmask;
	logic rst_low, sel_n, lp, rstop, wstop, pdw;
	logic respond, pdown, dnr, irq_n, low_pwr, func;
	int num_errors = 0, n_checks = 0, cyc = 0, idx;

	mmc_ctrl #(.INIT_CYC(INIT), .PDOWN_OFF_CYC(PDOFF)) dut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
		.module_rst_low_in_i(rst_low), .module_select_n_i(sel_n), .low_power_pin_i(lp),
		.rx_los_i(cond[3:0]), .tx_fault_i(cond[7:4]), .other_cond_i(cond[11:8]),
		.flag_read_stop_i(rstop), .flag_read_sel_i(rsel), .ctrl_write_stop_i(wstop),
		.mask_wdata_i(wmask), .pdown_wdata_i(pdw), .bus_respond_o(respond),
		.flags_o(flags), .mask_o(mask), .pdown_o(pdown), .data_not_ready_o(dnr),
		.irq_out_n_o(irq_n), .low_power_o(low_pwr), .functional_o(func));

	mmc_host_model u_host (
		.sys_clk_i(sys_clk_i), .data_not_ready_i(dnr),
		.module_rst_low_in_o(rst_low), .module_select_n_o(sel_n), .low_power_pin_o(lp),
		.flag_read_stop_o(rstop), .flag_read_sel_o(rsel), .ctrl_write_stop_o(wstop),
		.mask_wdata_o(wmask), .pdown_wdata_o(pdw));

	// ****************************************
	// clock, timeout, helpers
	// ****************************************
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// interrupt pin level expected from flags and masks, readiness irq already taken
	function automatic logic [11:0] irq_exp(input logic [11:0] f, input logic [11:0] m);
		return {11'h000, ~|(f & ~m)};
	endfunction

	// ****************************************
	// tests
	// ****************************************
	initial begin
		void'($urandom(25804));
		cond = 12'h000;
		arst_n_i = 1'b0;
		hold(16);
		arst_n_i = 1'b1;
		hold(4);
		check({dnr, irq_n, func}, 12'h006);
		hold(INIT + 8);
		check({dnr, irq_n, func, respond}, 12'h003);
		u_host.xfer(1'b1, 12'h000, 1'b0);
		hold(6);
		check(irq_n, 12'h001);
		$display("end init");

		for (int k = 0; k < 8; k++) begin
			idx = (k == 0) ? 0 : (k == 1) ? 11 : $urandom_range(11, 0);
			cond[idx] = 1'b1;
			hold(8);
			check(flags, 12'h001 << idx);
			check(irq_n, irq_exp(12'h001 << idx, 12'h000));
			cond[idx] = 1'b0;
			u_host.xfer(1'b1, 12'h001 << idx, 1'b0);
			hold(6);
			check(flags, 12'h000);
			check(irq_n, 12'h001);
		end
		cond = 12'h101;
		hold(8);
		u_host.xfer(1'b1, 12'h001, 1'b0);
		hold(6);
		check(flags, 12'h100);
		check(irq_n, 12'h000);
		cond = 12'h000;
		u_host.xfer(1'b1, 12'hfff, 1'b0);
		hold(6);
		check(irq_n, 12'h001);
		$display("end flags");

		idx = $urandom_range(11, 0);
		u_host.xfer(1'b0, 12'h001 << idx, 1'b0);
		hold(4);
		check(mask, 12'h001 << idx);
		cond[idx] = 1'b1;
		hold(8);
		check(flags, 12'h001 << idx);
		check(irq_n, irq_exp(12'h001 << idx, 12'h001 << idx));
		u_host.xfer(1'b0, 12'hfff, 1'b0);
		hold(4);
		check(mask, 12'hfff);
		check(irq_n, irq_exp(12'h001 << idx, 12'hfff));
		u_host.xfer(1'b0, 12'h000, 1'b0);
		hold(6);
		check(irq_n, 12'h000);
		cond[idx] = 1'b0;
		u_host.xfer(1'b1, 12'hfff, 1'b0);
		hold(6);
		check(irq_n, 12'h001);
		$display("end mask");

		u_host.pins(1'b1, 1'b1, 1'b0);
		hold(10);
		check(respond, 12'h000);
		u_host.pins(1'b1, 1'b0, 1'b0);
		hold(10);
		check(respond, 12'h001);
		$display("end select");

		u_host.pins(1'b1, 1'b0, 1'b1);
		hold(6);
		check(low_pwr, 12'h001);
		u_host.pins(1'b1, 1'b0, 1'b0);
		hold(PDOFF + 10);
		check({low_pwr, func}, 12'h001);
		u_host.xfer(1'b0, 12'h000, 1'b1);
		hold(6);
		check({pdown, low_pwr}, 12'h003);
		u_host.xfer(1'b0, 12'h000, 1'b0);
		hold(PDOFF + 10);
		check({pdown, low_pwr, func}, 12'h001);
		$display("end power");

		cond[5] = 1'b1;
		hold(8);
		cond[5] = 1'b0;
		u_host.pins(1'b0, 1'b0, 1'b0);
		hold(520);
		check(flags, 12'h000);
		check({dnr, irq_n, func}, 12'h006);
		u_host.pins(1'b1, 1'b0, 1'b0);
		hold(INIT + 10);
		check({dnr, irq_n, func}, 12'h001);
		$display("end module reset");
		report_and_stop();
	end
endmodule // tb_module_mgmt_ctrl_status_timing
`default_nettype wire
